// >>> verilog/cpr_pkg.sv
// constants, operation codes and register port map for the core register set
`default_nettype none
package cpr_pkg;
  // reset values
  localparam logic [15:0] STACK_RESET = 16'h00FF;
  localparam logic [15:0] FETCH_RESET = 16'h0000;
  localparam logic [7:0] IDX_HI_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] STACK_RELOAD_LOW = 8'hFF;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // flag bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // decimal correction
  localparam logic [7:0] BCD_LOW_ADJ = 8'h06;
  localparam logic [7:0] BCD_HIGH_ADJ = 8'h60;
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  // register port addresses
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_IDX_HI = 3'h1;
  localparam logic [2:0] REG_IDX_LO = 3'h2;
  localparam logic [2:0] REG_STK_HI = 3'h3;
  localparam logic [2:0] REG_STK_LO = 3'h4;
  localparam logic [2:0] REG_FETCH_HI = 3'h5;
  localparam logic [2:0] REG_FETCH_LO = 3'h6;
  localparam logic [2:0] REG_FLAGS = 3'h7;
  // instruction steps
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LOAD = 5'h01, OP_TEST = 5'h02, OP_LDHX = 5'h03,
    OP_ADD = 5'h04, OP_ADC = 5'h05, OP_SUB = 5'h06, OP_SBC = 5'h07,
    OP_CLR = 5'h08, OP_INC = 5'h09, OP_DEC = 5'h0A, OP_COM = 5'h0B,
    OP_NEG = 5'h0C, OP_LSL = 5'h0D, OP_LSR = 5'h0E, OP_ROL = 5'h0F,
    OP_ROR = 5'h10, OP_DECFIX = 5'h11, OP_STKADJ = 5'h12, OP_STKLOW = 5'h13,
    OP_MASKCLR = 5'h14, OP_SEI = 5'h15, OP_TAP = 5'h16, OP_TPA = 5'h17,
    OP_BTST = 5'h18
  } cpr_op_e;
  // byte register an 8-bit step works on
  typedef enum logic {TGT_ACC = 1'b0, TGT_IDX = 1'b1} cpr_tgt_e;
endpackage : cpr_pkg
`default_nettype wire

// >>> verilog/cpr_core_regs.sv
// programmer-visible register set of the 8-bit core: accumulator, index pair, stack, fetch pointer, flags
// Functional notes
// - accumulator keeps its content through reset.
// - accumulator feeds the ALU and takes ALU results back.
// - index pair is upper byte over lower byte, used as one 16-bit address.
// - lower index byte works alone as an 8-bit data register.
// - reset clears upper index byte, lower index byte untouched.
// - reset loads stack pointer with 00FF; it points at next free slot.
// - stack adjust adds sign-extended immediate to full stack pointer.
// - stack low reload changes only the stack pointer low byte.
// - fetch pointer increments per fetch unless flow change loads it.
// - after reset fetch pointer takes vector, high byte first then low.
// - flag bits 6 and 5 always read one.
// - overflow flag shows signed overflow of the result.
// - half carry shows carry from bit 3 to 4 on adds.
// - decimal fixup corrects last add using half carry and carry.
// - mask flag blocks interrupts; set on interrupt entry.
// - no interrupt right after an instruction that drops the mask.
// - negative flag follows result bit 7 (bit 15 on index pair load), loads and stores too.
// - zero flag set for all-zero results, loads and stores.
// - carry flag from add carry, subtract borrow, shifts and bit tests.
// - registers are not memory mapped, only reached by the sequencer.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
module cpr_core_regs import cpr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // instruction step from the sequencer
  input wire logic opValid,
  input wire cpr_op_e opCode,
  input wire cpr_tgt_e opTarget,
  input wire logic [7:0] opData,
  input wire logic [15:0] opWide,
  // program flow
  input wire logic fetchStep,
  input wire logic flowLoad,
  input wire logic [15:0] flowAddr,
  input wire logic vecHiLoad,
  input wire logic vecLoLoad,
  input wire logic [7:0] vecByte,
  input wire logic intEntry,
  // sequencer register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // register views
  output logic [7:0] accOut,
  output logic [15:0] indexOut,
  output logic [15:0] stackOut,
  output logic [15:0] fetchPtrOut,
  output logic [7:0] flagsOut,
  output logic irqAllow
);

  logic [7:0] acc_r;
  logic [7:0] idxHi_r;
  logic [7:0] idxLo_r;
  logic [15:0] stkPtr_r;
  logic [15:0] fetchPtr_r;
  logic [7:0] flag_r;
  logic [7:0] flag_nxt;
  logic inhibit_r;
  logic inhibit_nxt;
  logic irqAllow_r;
  logic [7:0] rdData_r;

  // step result
  logic [7:0] srcVal;
  logic [7:0] resVal;
  logic resWr;
  logic resToAcc;
  logic [7:0] flagOp;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic cin;
  logic nzUpd;
  logic nzWide;
  logic [15:0] nzVal;
  logic bcdHi;
  logic bcdLo;

  // outputs are the flops themselves
  assign accOut = acc_r;
  assign indexOut = {idxHi_r, idxLo_r};
  assign stackOut = stkPtr_r;
  assign fetchPtrOut = fetchPtr_r;
  assign flagsOut = flag_r;
  assign irqAllow = irqAllow_r;
  assign regRdData = rdData_r;

  function automatic logic portHit(input logic wr, input logic [2:0] a, input logic [2:0] reg_a);
    portHit = wr && (a == reg_a);
  endfunction : portHit

  // operand source: accumulator or the lower index byte
  assign srcVal = (opTarget == TGT_IDX) ? idxLo_r : acc_r;

  // ALU result and flag effects of one step
  always_comb begin
    resVal = srcVal;
    resWr = 1'b0;
    resToAcc = (opTarget == TGT_ACC);
    flagOp = flag_r;
    cin = 1'b0;
    sum9 = 9'h000;
    half5 = 5'h00;
    nzUpd = 1'b0;
    nzWide = 1'b0;
    nzVal = 16'h0000;
    bcdHi = 1'b0;
    bcdLo = 1'b0;
    case (opCode)
      OP_LOAD: begin
        resVal = opData;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = 1'b0;
      end
      OP_TEST: begin
        // store or compare-free test: flags only
        resVal = opData;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = 1'b0;
      end
      OP_LDHX: begin
        nzUpd = 1'b1;
        nzWide = 1'b1;
        nzVal = opWide;
        flagOp[FLAG_V] = 1'b0;
      end
      OP_ADD, OP_ADC: begin
        cin = (opCode == OP_ADC) && flag_r[FLAG_C];
        sum9 = {1'b0, srcVal} + {1'b0, opData} + {8'h00, cin};
        half5 = {1'b0, srcVal[3:0]} + {1'b0, opData[3:0]} + {4'h0, cin};
        resVal = sum9[7:0];
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_H] = half5[4];
        flagOp[FLAG_C] = sum9[8];
        flagOp[FLAG_V] = (srcVal[7] == opData[7]) && (sum9[7] != srcVal[7]);
      end
      OP_SUB, OP_SBC: begin
        cin = (opCode == OP_SBC) && flag_r[FLAG_C];
        sum9 = {1'b0, srcVal} - {1'b0, opData} - {8'h00, cin};
        resVal = sum9[7:0];
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_C] = sum9[8]; // borrow
        flagOp[FLAG_V] = (srcVal[7] != opData[7]) && (sum9[7] != srcVal[7]);
      end
      OP_CLR: begin
        resVal = 8'h00;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = 1'b0;
      end
      OP_INC: begin
        resVal = srcVal + 8'h01;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = (srcVal == 8'h7F);
      end
      OP_DEC: begin
        resVal = srcVal - 8'h01;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = (srcVal == 8'h80);
      end
      OP_COM: begin
        resVal = ~srcVal;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = 1'b0;
        flagOp[FLAG_C] = 1'b1;
      end
      OP_NEG: begin
        resVal = 8'h00 - srcVal;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_V] = (srcVal == 8'h80);
        flagOp[FLAG_C] = (srcVal != 8'h00);
      end
      OP_LSL, OP_LSR, OP_ROL, OP_ROR: begin
        // shifted-out bit goes to carry, overflow is N xor C
        case (opCode)
          OP_LSL: resVal = {srcVal[6:0], 1'b0};
          OP_LSR: resVal = {1'b0, srcVal[7:1]};
          OP_ROL: resVal = {srcVal[6:0], flag_r[FLAG_C]};
          default: resVal = {flag_r[FLAG_C], srcVal[7:1]};
        endcase
        flagOp[FLAG_C] = (opCode == OP_LSL || opCode == OP_ROL) ? srcVal[7] : srcVal[0];
        flagOp[FLAG_V] = resVal[7] ^ flagOp[FLAG_C];
        resWr = 1'b1;
        nzUpd = 1'b1;
      end
      OP_DECFIX: begin
        // correction per nibble; carry only ever set, never cleared
        bcdLo = flag_r[FLAG_H] || (acc_r[3:0] > BCD_NIB_MAX);
        bcdHi = flag_r[FLAG_C] || (acc_r > BCD_BYTE_MAX);
        resVal = acc_r + (bcdLo ? BCD_LOW_ADJ : 8'h00) + (bcdHi ? BCD_HIGH_ADJ : 8'h00);
        resToAcc = 1'b1;
        resWr = 1'b1;
        nzUpd = 1'b1;
        flagOp[FLAG_C] = bcdHi;
      end
      OP_MASKCLR: flagOp[FLAG_I] = 1'b0;
      OP_SEI: flagOp[FLAG_I] = 1'b1;
      OP_TAP: flagOp = acc_r;
      OP_TPA: begin
        resVal = flag_r;
        resToAcc = 1'b1;
        resWr = 1'b1;
      end
      OP_BTST: flagOp[FLAG_C] = opData[0]; // tested bit arrives in bit 0
      default: resVal = srcVal;
    endcase
    if (nzUpd) begin
      if (!nzWide) begin
        nzVal = {8'h00, resVal};
      end
      flagOp[FLAG_N] = nzWide ? nzVal[15] : nzVal[7];
      flagOp[FLAG_Z] = (nzVal == 16'h0000);
    end
    flagOp = flagOp | FLAGS_FIXED;
  end

  // flag next value: step, then port, entry sets the mask last
  always_comb begin
    flag_nxt = flag_r;
    if (opValid) begin
      flag_nxt = flagOp;
    end else if (portHit(regWr, regAddr, REG_FLAGS)) begin
      flag_nxt = regWrData | FLAGS_FIXED;
    end
    if (intEntry) begin
      flag_nxt[FLAG_I] = 1'b1;
    end
  end

  // interrupt shadow lasts until the next step completes
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (opValid) begin
      inhibit_nxt = flag_r[FLAG_I] && !flag_nxt[FLAG_I];
    end
  end

  // flags, shadow and interrupt permission
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= FLAGS_RESET;
      inhibit_r <= 1'b0;
      irqAllow_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      inhibit_r <= inhibit_nxt;
      irqAllow_r <= !flag_nxt[FLAG_I] && !inhibit_nxt;
    end
  end

  // accumulator has no reset; steps are ignored while reset is held
  always_ff @(posedge core_clk) begin
    if (reset_n) begin
      if (opValid && resWr && resToAcc) begin
        acc_r <= resVal;
      end else if (!opValid && portHit(regWr, regAddr, REG_ACC)) begin
        acc_r <= regWrData;
      end
    end
  end

  // lower index byte also survives reset
  always_ff @(posedge core_clk) begin
    if (reset_n) begin
      if (opValid && opCode == OP_LDHX) begin
        idxLo_r <= opWide[7:0];
      end else if (opValid && resWr && !resToAcc) begin
        idxLo_r <= resVal;
      end else if (!opValid && portHit(regWr, regAddr, REG_IDX_LO)) begin
        idxLo_r <= regWrData;
      end
    end
  end

  // upper index byte
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idxHi_r <= IDX_HI_RESET;
    end else if (opValid && opCode == OP_LDHX) begin
      idxHi_r <= opWide[15:8];
    end else if (!opValid && portHit(regWr, regAddr, REG_IDX_HI)) begin
      idxHi_r <= regWrData;
    end
  end

  // stack pointer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stkPtr_r <= STACK_RESET;
    end else if (opValid && opCode == OP_STKADJ) begin
      stkPtr_r <= stkPtr_r + {{8{opData[7]}}, opData};
    end else if (opValid && opCode == OP_STKLOW) begin
      stkPtr_r[7:0] <= STACK_RELOAD_LOW;
    end else if (!opValid && portHit(regWr, regAddr, REG_STK_HI)) begin
      stkPtr_r[15:8] <= regWrData;
    end else if (!opValid && portHit(regWr, regAddr, REG_STK_LO)) begin
      stkPtr_r[7:0] <= regWrData;
    end
  end

  // fetch pointer: vector bytes, flow change, then sequential step
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchPtr_r <= FETCH_RESET;
    end else if (vecHiLoad) begin
      fetchPtr_r[15:8] <= vecByte;
    end else if (vecLoLoad) begin
      fetchPtr_r[7:0] <= vecByte;
    end else if (flowLoad) begin
      fetchPtr_r <= flowAddr;
    end else if (fetchStep) begin
      fetchPtr_r <= fetchPtr_r + 16'h0001;
    end else if (portHit(regWr, regAddr, REG_FETCH_HI)) begin
      fetchPtr_r[15:8] <= regWrData;
    end else if (portHit(regWr, regAddr, REG_FETCH_LO)) begin
      fetchPtr_r[7:0] <= regWrData;
    end
  end

  // read data stand for one cycle only; the port is private to the sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r <= RDATA_IDLE;
    end else if (regRd) begin
      case (regAddr)
        REG_ACC: rdData_r <= acc_r;
        REG_IDX_HI: rdData_r <= idxHi_r;
        REG_IDX_LO: rdData_r <= idxLo_r;
        REG_STK_HI: rdData_r <= stkPtr_r[15:8];
        REG_STK_LO: rdData_r <= stkPtr_r[7:0];
        REG_FETCH_HI: rdData_r <= fetchPtr_r[15:8];
        REG_FETCH_LO: rdData_r <= fetchPtr_r[7:0];
        default: rdData_r <= flag_r;
      endcase
    end else begin
      rdData_r <= RDATA_IDLE;
    end
  end

  // checks on the registers
  chk_acc_reset_hold: assert property (@(posedge core_clk) !reset_n |=> $stable(acc_r))
    else $error("accumulator changed during reset");

  chk_reset_values: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> stkPtr_r == STACK_RESET && idxHi_r == IDX_HI_RESET)
    else $error("stack or upper index wrong after reset");

  chk_fixed_ones: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_TAP |=> (flag_r & FLAGS_FIXED) == FLAGS_FIXED && flag_r[4:0] == $past(acc_r[4:0]))
    else $error("flag transfer broke fixed bits");

  chk_stack_adjust: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_STKADJ |=> stkPtr_r == $past(stkPtr_r) + {{8{$past(opData[7])}}, $past(opData)})
    else $error("stack adjust not sign extended");

  chk_stack_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_STKLOW |=> stkPtr_r[15:8] == $past(stkPtr_r[15:8]) && stkPtr_r[7:0] == STACK_RELOAD_LOW)
    else $error("stack low reload touched high byte");

  chk_fetch_step: assert property (@(posedge core_clk) disable iff (!reset_n)
    fetchStep && !flowLoad && !vecHiLoad && !vecLoLoad |=> fetchPtr_r == $past(fetchPtr_r) + 16'h0001)
    else $error("fetch pointer did not step");

  chk_mask_shadow: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_MASKCLR && flag_r[3] && !intEntry |=> !irqAllow_r ##1 (!irqAllow_r || !$past(opValid)))
    else $error("interrupt allowed right after mask drop");

  chk_entry_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    intEntry |=> flag_r[FLAG_I] && !irqAllow_r)
    else $error("interrupt entry left mask clear");

  chk_half_carry: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_ADD |=> flag_r[4] == (({1'b0, $past(srcVal[3:0])} + {1'b0, $past(opData[3:0])}) > 5'h0F))
    else $error("half carry wrong after add");

  chk_load_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    opValid && opCode == OP_LOAD |=> flag_r[1] == ($past(opData) == 8'h00) && flag_r[2] == $past(opData[7]))
    else $error("load flags wrong");

  chk_read_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRd && regAddr == REG_STK_LO |=> regRdData == $past(stkPtr_r[7:0]))
    else $error("read data late or wrong");

endmodule : cpr_core_regs
`default_nettype wire

// >>> tb/cpr_seq_model.sv
// sequencer stand-in that drives the step, flow and register ports
`default_nettype none
module cpr_seq_model import cpr_pkg::*; (
  // clock
  input wire logic core_clk,
  // instruction steps
  output logic opValid,
  output cpr_op_e opCode,
  output cpr_tgt_e opTarget,
  output logic [7:0] opData,
  output logic [15:0] opWide,
  // program flow
  output logic fetchStep,
  output logic flowLoad,
  output logic [15:0] flowAddr,
  output logic vecHiLoad,
  output logic vecLoLoad,
  output logic [7:0] vecByte,
  output logic intEntry,
  // register port
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 100ps;

  // everything idle at time zero
  initial begin
    {opValid, fetchStep, flowLoad, vecHiLoad, vecLoLoad, intEntry, regWr, regRd} = 8'h00;
    opCode = OP_NOP;
    opTarget = TGT_ACC;
    {opData, opWide, flowAddr, vecByte, regAddr, regWrData} = 59'h0;
  end

  // one completed instruction step; operands are inverted afterwards so stale values never pass for fresh ones
  task automatic step(input cpr_op_e op, input logic [7:0] d, input cpr_tgt_e tg = TGT_ACC,
                      input logic [15:0] w = 16'h0000);
    @(posedge core_clk);
    opValid <= 1'b1;
    opCode <= op;
    opTarget <= tg;
    opData <= d;
    opWide <= w;
    @(posedge core_clk);
    opValid <= 1'b0;
    opData <= ~d;
    opWide <= ~w;
    #1;
  endtask : step

  // single flow pulse: k[0] fetch, k[1] flow load, k[2] interrupt entry
  task automatic pulse(input logic [2:0] k, input logic [15:0] a = 16'h0000);
    @(posedge core_clk);
    {intEntry, flowLoad, fetchStep} <= k;
    flowAddr <= a;
    @(posedge core_clk);
    {intEntry, flowLoad, fetchStep} <= 3'h0;
    flowAddr <= ~a;
    #1;
  endtask : pulse

  // reset vector fetch, high byte then low byte
  task automatic vector(input logic [15:0] v);
    @(posedge core_clk);
    vecHiLoad <= 1'b1;
    vecByte <= v[15:8];
    @(posedge core_clk);
    vecHiLoad <= 1'b0;
    vecLoLoad <= 1'b1;
    vecByte <= v[7:0];
    @(posedge core_clk);
    vecLoLoad <= 1'b0;
    vecByte <= ~v[7:0];
    #1;
  endtask : vector

  // register port write, one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    regWrData <= ~d;
    #1;
  endtask : wr

  // register port read: data in the cycle after the strobe, idle value one cycle later
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] idle);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    @(posedge core_clk);
    #1;
    idle = regRdData;
  endtask : rd
endmodule : cpr_seq_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the core register set
`default_nettype none
module tb_top import cpr_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk;
  logic reset_n;
  logic opValid, fetchStep, flowLoad, vecHiLoad, vecLoLoad, intEntry, regWr, regRd, irqAllow;
  cpr_op_e opCode;
  cpr_tgt_e opTarget;
  logic [7:0] opData, vecByte, regWrData, regRdData, accOut, flagsOut, rdv, idl;
  logic [15:0] opWide, flowAddr, indexOut, stackOut, fetchPtrOut;
  logic [2:0] regAddr;
  int nFail;
  int checksDone;
  cpr_op_e dropOps[2] = '{OP_TAP, OP_MASKCLR};

  cpr_core_regs uut (.core_clk(core_clk), .reset_n(reset_n), .opValid(opValid), .opCode(opCode),
    .opTarget(opTarget), .opData(opData), .opWide(opWide), .fetchStep(fetchStep), .flowLoad(flowLoad),
    .flowAddr(flowAddr), .vecHiLoad(vecHiLoad), .vecLoLoad(vecLoLoad), .vecByte(vecByte),
    .intEntry(intEntry), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .accOut(accOut), .indexOut(indexOut), .stackOut(stackOut), .fetchPtrOut(fetchPtrOut),
    .flagsOut(flagsOut), .irqAllow(irqAllow));

  cpr_seq_model seq (.core_clk(core_clk), .opValid(opValid), .opCode(opCode), .opTarget(opTarget),
    .opData(opData), .opWide(opWide), .fetchStep(fetchStep), .flowLoad(flowLoad), .flowAddr(flowAddr),
    .vecHiLoad(vecHiLoad), .vecLoLoad(vecLoLoad), .vecByte(vecByte), .intEntry(intEntry),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // hang guard: every wait below is fixed, this only catches a stuck simulation
  initial begin
    repeat (3000) @(posedge core_clk);
    nFail++;
    $display("unexpected run length");
    finish_test();
  end

  initial begin
    nFail = 0;
    checksDone = 0;
    reset_n = 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk8("idx hi", 8'h00, indexOut[15:8]);
    chk16("stack", 16'h00FF, stackOut);
    chk16("fetch ptr", FETCH_RESET, fetchPtrOut);
    chk8("flags", FLAGS_RESET, flagsOut);
    chk8("irq", 8'h00, {7'h00, irqAllow});
    seq.wr(REG_ACC, 8'h5A);
    seq.wr(REG_IDX_HI, 8'h77);
    seq.wr(REG_IDX_LO, 8'h3C);
    chk16("index", 16'h773C, indexOut);
    // second reset in mid-run: acc and lower index byte survive
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk8("acc", 8'h5A, accOut);
    chk16("index", 16'h003C, indexOut);
    $display("test reset done");
    seq.rd(REG_STK_LO, rdv, idl);
    chk8("rd stack lo", 8'hFF, rdv);
    chk8("rd idle", RDATA_IDLE, idl);
    seq.rd(REG_ACC, rdv, idl);
    chk8("rd acc", 8'h5A, rdv);
    $display("test port done");
    // add with signed overflow and half carry, then carry out, then add with carry
    seq.wr(REG_ACC, 8'h78);
    seq.step(OP_ADD, 8'h08);
    chk8("acc", 8'h80, accOut);
    chk8("flags", 8'hFC, flagsOut);
    seq.step(OP_ADD, 8'h80);
    chk8("acc", 8'h00, accOut);
    chk8("flags", 8'hEB, flagsOut);
    seq.step(OP_ADC, 8'h0F);
    chk8("acc", 8'h10, accOut);
    chk8("flags", 8'h78, flagsOut);
    seq.wr(REG_ACC, 8'h09);
    seq.step(OP_ADD, 8'h08);
    seq.step(OP_DECFIX, 8'h00);
    chk8("acc", 8'h17, accOut);
    seq.wr(REG_ACC, 8'h00);
    seq.step(OP_SUB, 8'h01);
    chk8("acc", 8'hFF, accOut);
    chk8("flags nzc", 8'h05, {5'h00, flagsOut[2:0]});
    // bit test moves the tested bit into carry, a store sets zero, flags copy back into the accumulator
    seq.step(OP_BTST, 8'h00);
    chk8("flags nzc", 8'h04, {5'h00, flagsOut[2:0]});
    seq.step(OP_TEST, 8'h00);
    chk8("flags nzc", 8'h02, {5'h00, flagsOut[2:0]});
    seq.step(OP_TPA, 8'h00);
    chk8("acc", 8'h7A, accOut);
    $display("test alu done");
    // index pair as one value, lower byte alone as a data register
    seq.step(OP_LDHX, 8'h00, TGT_ACC, 16'h92FF);
    chk16("index", 16'h92FF, indexOut);
    chk8("flags nz", 8'h02, {6'h00, flagsOut[2:1]});
    seq.step(OP_INC, 8'h00, TGT_IDX);
    chk16("index", 16'h9200, indexOut);
    chk8("flags nz", 8'h01, {6'h00, flagsOut[2:1]});
    seq.wr(REG_IDX_LO, 8'h80);
    seq.step(OP_LSL, 8'h00, TGT_IDX);
    chk16("index", 16'h9200, indexOut);
    chk8("flags nzc", 8'h03, {5'h00, flagsOut[2:0]});
    $display("test index done");
    // stack adjust with negative and carrying immediates, then low reload
    seq.step(OP_STKADJ, 8'hFE);
    chk16("stack", 16'h00FD, stackOut);
    seq.step(OP_STKADJ, 8'h05);
    chk16("stack", 16'h0102, stackOut);
    seq.wr(REG_STK_HI, 8'h12);
    seq.step(OP_STKLOW, 8'h00);
    chk16("stack", 16'h12FF, stackOut);
    $display("test stack done");
    seq.vector(16'hABCD);
    chk16("fetch ptr", 16'hABCD, fetchPtrOut);
    seq.pulse(3'b001);
    chk16("fetch ptr", 16'hABCE, fetchPtrOut);
    seq.pulse(3'b010, 16'h1234);
    chk16("fetch ptr", 16'h1234, fetchPtrOut);
    seq.rd(REG_FETCH_LO, rdv, idl);
    chk8("rd fetch lo", 8'h34, rdv);
    $display("test flow done");
    seq.wr(REG_FLAGS, 8'h00);
    seq.rd(REG_FLAGS, rdv, idl);
    chk8("rd flags", FLAGS_FIXED, rdv);
    // mask set on entry, then no interrupt at the boundary after the mask drop
    seq.wr(REG_ACC, 8'h00);
    foreach (dropOps[i]) begin
      seq.pulse(3'b100);
      @(posedge core_clk);
      #1;
      chk8("mask", 8'h01, {7'h00, flagsOut[FLAG_I]});
      chk8("irq", 8'h00, {7'h00, irqAllow});
      seq.step(dropOps[i], 8'h00);
      @(posedge core_clk);
      #1;
      chk8("mask", 8'h00, {7'h00, flagsOut[FLAG_I]});
      chk8("irq", 8'h00, {7'h00, irqAllow});
      seq.step(OP_NOP, 8'h00);
      @(posedge core_clk);
      #1;
      chk8("irq", 8'h01, {7'h00, irqAllow});
    end
    $display("test mask done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
